// *** common/tse_pkg.sv ***
package tse_pkg;
  // register map
  localparam logic [3:0]  ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_STATUS  = 4'h4;
  localparam logic [3:0]  ADDR_DIN     = 4'h8;
  localparam logic [3:0]  ADDR_LEVEL   = 4'hc;
  // control register layout
  localparam int          CTRL_W       = 11;
  localparam logic [10:0] CTRL_RESET   = 11'h000;
  localparam int          CTRL_MOD_LSB = 0;
  localparam int          CTRL_CT_BIT  = 7;
  localparam int          CTRL_CONT_BIT = 8;
  localparam int          CTRL_SER_LSB = 9;
  // counter set
  localparam int          NUM_CNT      = 32;
  localparam int          CNT_W        = 32;
  // event group types and state masks
  localparam logic [1:0]  EVT_SINGLE   = 2'h1;
  localparam logic [1:0]  EVT_PAIR     = 2'h2;
  localparam logic [1:0]  EVT_OCTET    = 2'h3;
  localparam logic [7:0]  MASK_SINGLE  = 8'h01;
  localparam logic [7:0]  MASK_PAIR    = 8'h03;
  localparam logic [7:0]  MASK_OCTET   = 8'hff;
  localparam logic [15:0] MS_INVALID   = 16'hffff;
  // status word
  localparam logic [1:0]  STAT_HOLD    = 2'h2;
  localparam int          STAT_TU      = 3;
  localparam int          STAT_PF      = 5;
  localparam int          STAT_PH      = 6;
  // multiplex contents
  localparam logic [1:0]  MUX_NONE     = 2'h0;
  localparam logic [1:0]  MUX_EVENT    = 2'h1;
  localparam logic [1:0]  MUX_COUNT    = 2'h2;
  localparam logic [1:0]  MUX_STATUS   = 2'h3;
  typedef enum logic [1:0] {D_IDLE, D_SHOW, D_GAP} tse_dlv_type;
endpackage

// *** hw/tse_transfer.sv ***
// Functional notes
// [RQ1] digital input words refreshed every cycle
// [RQ2] counters published as full set, one-cycle flag
// [RQ3] record and ready held until accept
// [RQ4] ready drops a cycle, then next loads
// [RQ5] host releases accept after ready drops
// [RQ6] further events wait in event FIFO
// [RQ7] continuous mode: one-cycle pulses, two apart
// [RQ8] one-cycle clear empties the event FIFO
// [RQ9] one-cycle clear zeroes all counters
// [RQ10] byte 1: module number, coarse-time flag
// [RQ11] byte 2: first input, type, or month
// [RQ12] type codes 01 single, 10 pair, 11 octet
// [RQ13] byte 3: right-aligned states or year
// [RQ14] bytes 4-5: milliseconds within the minute
// [RQ15] byte 6: minutes, zero, time-invalid flag
// [RQ16] time invalid forces milliseconds to all ones
// [RQ17] byte 7: hours, reserved, summer-time flag
// [RQ18] byte 8: day of month, day of week
// [RQ19] coarse record on listed trigger events
// [RQ20] coarse record precedes next event, copies time
// [RQ21] status flag one cycle, word held two
// [RQ22] host errors 15:12, module errors below
// [RQ23] seven transfer words incl. four multiplex words
// [RQ24] flags low and FIFO empty after reset
`timescale 1ns/100ps
`default_nettype none
module tse_transfer #(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // register port
  input  wire logic [3:0]            i_addr,
  input  wire logic [31:0]           i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic [31:0]                o_rdata,
  // digital input pins, input 1 on bit 0
  input  wire logic [31:0]           i_din_pins,
  // counter series source, two values per beat
  input  wire logic                  i_cnt_valid,
  input  wire logic [63:0]           i_cnt_pair,
  // event source
  input  wire logic                  i_evt_valid,
  input  wire logic [1:0]            i_evt_type,
  input  wire logic [5:0]            i_evt_first,
  input  wire logic [7:0]            i_evt_states,
  // module clock
  input  wire logic [15:0]           i_time_ms,
  input  wire logic [5:0]            i_time_min,
  input  wire logic                  i_time_invalid,
  input  wire logic [4:0]            i_time_hour,
  input  wire logic                  i_time_summer,
  input  wire logic [4:0]            i_time_dom,
  input  wire logic [2:0]            i_time_dow,
  input  wire logic [7:0]            i_time_month,
  input  wire logic [7:0]            i_time_year,
  input  wire logic                  i_clock_set,
  // host controls and errors
  input  wire logic                  i_prog_run,
  input  wire logic                  i_event_accept,
  input  wire logic                  i_clear_event_queue,
  input  wire logic                  i_clear_counters,
  input  wire logic [3:0]            i_host_err,
  input  wire logic [8:0]            i_module_err,
  // transfer block
  output logic [15:0]                o_din_word0,
  output logic [15:0]                o_din_word1,
  output logic [15:0]                o_transfer_status,
  output logic [63:0]                o_mux_word,
  // host-side results
  output logic [63:0]                o_event_record,
  output logic                       o_event_ready_flag,
  output logic [tse_pkg::NUM_CNT*tse_pkg::CNT_W-1:0] o_counter_set,
  output logic                       o_counts_ready_flag,
  output logic [15:0]                o_status_word,
  output logic                       o_status_ready_flag
);
  import tse_pkg::*;

  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int EW = 81;
  localparam logic [AW:0] DEPTH = (AW+1)'(FIFO_DEPTH);
  localparam logic [AW:0] HALF  = (AW+1)'(FIFO_DEPTH / 2);

  function automatic logic [7:0] type_mask(input logic [1:0] t);
    unique case (t)
      EVT_SINGLE: type_mask = MASK_SINGLE;
      EVT_PAIR:   type_mask = MASK_PAIR;
      EVT_OCTET:  type_mask = MASK_OCTET;
      default:    type_mask = 8'h00;
    endcase
  endfunction

  logic [31:0]             din_s1_reg, din_s2_reg, din_word_reg, din_word_next;
  logic [CTRL_W-1:0]       ctrl_reg, ctrl_next;
  logic                    run_d_reg;
  logic [7:0]              month_d_reg;
  logic [EW-1:0]           mem_reg [FIFO_DEPTH];
  logic [EW-1:0]           mem_next [FIFO_DEPTH];
  logic [AW:0]             wp_reg, wp_next, rp_reg, rp_next;
  logic                    overrun_reg, overrun_next;
  logic                    ct_pend_reg, ct_pend_next;
  logic                    ct_done_reg, ct_done_next;
  tse_dlv_type             dstate_reg, dstate_next;
  logic [63:0]             rec_reg, rec_next;
  logic [63:0]             mux_reg, mux_next;
  logic [1:0]              kind_reg, kind_next;
  logic [5:0]              seq_reg, seq_next;
  logic [NUM_CNT-1:0][CNT_W-1:0] sh_reg, sh_next, pub_reg, pub_next;
  logic [3:0]              pair_reg, pair_next;
  logic                    cr_reg, cr_next;
  logic [15:0]             stat_reg, stat_next;
  logic                    sr_reg, sr_next;
  logic [1:0]              hold_reg, hold_next;
  logic [31:0]             rdata_reg, rdata_next;

  logic [AW:0]             level;
  logic                    empty, full, cont, ct_en, trig, push, drop;
  logic [EW-1:0]           head;
  logic [6:0]              modnum;
  logic [3:0]              last_pair;
  logic [8:0]              mod_err;
  logic [15:0]             new_stat;
  logic [15:0]             msv;
  logic [AW:0]             wp_b, rp_b;

  assign level  = wp_reg - rp_reg;
  assign empty  = (wp_reg == rp_reg);
  assign full   = (level == DEPTH);
  assign cont   = ctrl_reg[CTRL_CONT_BIT];
  assign ct_en  = ctrl_reg[CTRL_CT_BIT];
  assign modnum = ctrl_reg[CTRL_MOD_LSB +: 7];
  assign head   = mem_reg[rp_reg[AW-1:0]];

  always_comb begin
    din_word_next = {<<{din_s2_reg}};                       // RQ1
    ctrl_next     = ctrl_reg;
    mem_next      = mem_reg;
    wp_next       = wp_reg;
    rp_next       = rp_reg;
    overrun_next  = overrun_reg;
    ct_done_next  = ct_done_reg;
    dstate_next   = dstate_reg;
    rec_next      = rec_reg;
    mux_next      = mux_reg;
    kind_next     = kind_reg;
    seq_next      = seq_reg;
    sh_next       = sh_reg;
    pub_next      = pub_reg;
    pair_next     = pair_reg;
    cr_next       = 1'b0;
    stat_next     = stat_reg;
    sr_next       = 1'b0;
    hold_next     = hold_reg;
    rdata_next    = 32'h0000_0000;
    if (i_wr && i_addr == ADDR_CTRL) begin
      ctrl_next = i_wdata[CTRL_W-1:0];
    end
    // coarse-time triggers; a trigger in the push cycle rides on that event
    trig = (i_time_month != month_d_reg) || i_clock_set
           || (i_prog_run != run_d_reg) || i_clear_event_queue;  // RQ19
    // a clear and a new event in one cycle: queue emptied, new event kept
    wp_b = i_clear_event_queue ? '0 : wp_reg;                     // RQ8
    rp_b = i_clear_event_queue ? '0 : rp_reg;
    push = i_evt_valid && (i_clear_event_queue || !full);
    drop = i_evt_valid && !push;
    msv  = i_time_invalid ? MS_INVALID : i_time_ms;               // RQ16
    if (i_clear_event_queue) begin
      ct_done_next = 1'b0;
    end
    if (push) begin                                               // RQ6
      mem_next[wp_b[AW-1:0]] = {ct_en && (ct_pend_reg || trig),
        i_time_month, i_time_year,
        i_time_dow, i_time_dom,                                   // RQ18
        i_time_summer, 2'b00, i_time_hour,                        // RQ17
        i_time_invalid, 1'b0, i_time_min,                         // RQ15
        msv[15:8], msv[7:0],                                      // RQ14
        i_evt_states & type_mask(i_evt_type),                     // RQ13
        i_evt_type, i_evt_first,                                  // RQ11 RQ12
        1'b0, modnum};                                            // RQ10
      wp_next = wp_b + 1'b1;
    end else begin
      wp_next = wp_b;
    end
    rp_next      = rp_b;
    ct_pend_next = push ? 1'b0 : (ct_pend_reg || trig);
    overrun_next = (overrun_reg && !i_clear_event_queue) || drop;
    unique case (dstate_reg)
      D_IDLE: begin
        if (!empty && !i_clear_event_queue && (!cont || i_event_accept)) begin
          if (head[80] && !ct_done_reg) begin
            // coarse record first; the event stays queued right behind it
            rec_next     = {head[63:24], head[71:64], head[79:72],
                            1'b1, head[6:0]};                     // RQ20
            ct_done_next = 1'b1;
          end else begin
            rec_next     = head[63:0];
            rp_next      = rp_reg + 1'b1;
            ct_done_next = 1'b0;
          end
          mux_next    = rec_next;                                 // RQ23
          kind_next   = MUX_EVENT;
          seq_next    = seq_reg + 6'h01;
          dstate_next = D_SHOW;
        end
      end
      D_SHOW: begin
        if (cont || i_event_accept) begin                         // RQ3 RQ7
          dstate_next = D_GAP;
        end
      end
      D_GAP: begin
        dstate_next = D_IDLE;                                     // RQ4
      end
    endcase
    last_pair = {ctrl_reg[CTRL_SER_LSB +: 2], 2'b11};
    if (i_clear_counters) begin                                   // RQ9
      sh_next   = '0;
      pub_next  = '0;
      pair_next = '0;
    end else if (i_cnt_valid) begin
      sh_next[{pair_reg, 1'b0}] = i_cnt_pair[31:0];
      sh_next[{pair_reg, 1'b1}] = i_cnt_pair[63:32];
      // only a record loaded in this very cycle outranks a counter beat
      if (!(dstate_reg == D_IDLE && dstate_next == D_SHOW)) begin
        mux_next  = i_cnt_pair;
        kind_next = MUX_COUNT;
        seq_next  = seq_reg + 6'h01;
      end
      if (pair_reg == last_pair) begin                            // RQ2
        pub_next  = sh_next;
        pair_next = '0;
        cr_next   = 1'b1;
      end else begin
        pair_next = pair_reg + 4'h1;
      end
    end
    mod_err          = i_module_err;
    mod_err[STAT_TU] = i_module_err[STAT_TU] | i_time_invalid;
    mod_err[STAT_PF] = i_module_err[STAT_PF] | overrun_reg;
    mod_err[STAT_PH] = i_module_err[STAT_PH] | (level >= HALF);
    new_stat = {i_host_err, 3'b000, mod_err};                     // RQ22
    // new status waits out the hold so each word stays for at least three cycles
    if (hold_reg != 2'h0) begin
      hold_next = hold_reg - 2'h1;
    end else if (new_stat != stat_reg) begin                      // RQ21
      stat_next = new_stat;
      sr_next   = 1'b1;
      hold_next = STAT_HOLD;
      if (kind_next == kind_reg && seq_next == seq_reg) begin
        mux_next  = {48'h0, new_stat};
        kind_next = MUX_STATUS;
        seq_next  = seq_reg + 6'h01;
      end
    end
    if (i_rd) begin
      unique case (i_addr)
        ADDR_CTRL:   rdata_next = {21'h0, ctrl_reg};
        ADDR_STATUS: rdata_next = {16'h0, stat_reg};
        ADDR_DIN:    rdata_next = din_word_reg;
        ADDR_LEVEL:  rdata_next = 32'(level);
        default:     rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      din_s1_reg   <= '0;
      din_s2_reg   <= '0;
      din_word_reg <= '0;
      ctrl_reg     <= CTRL_RESET;
      run_d_reg    <= 1'b0;
      month_d_reg  <= '0;
      mem_reg      <= '{default: '0};
      wp_reg       <= '0;                                         // RQ24
      rp_reg       <= '0;
      overrun_reg  <= 1'b0;
      ct_pend_reg  <= 1'b1;                                       // restart counts as a trigger
      ct_done_reg  <= 1'b0;
      dstate_reg   <= D_IDLE;
      rec_reg      <= '0;
      mux_reg      <= '0;
      kind_reg     <= MUX_NONE;
      seq_reg      <= '0;
      sh_reg       <= '0;
      pub_reg      <= '0;
      pair_reg     <= '0;
      cr_reg       <= 1'b0;
      stat_reg     <= '0;
      sr_reg       <= 1'b0;
      hold_reg     <= '0;
      rdata_reg    <= '0;
    end else begin
      din_s1_reg   <= i_din_pins;
      din_s2_reg   <= din_s1_reg;
      din_word_reg <= din_word_next;
      ctrl_reg     <= ctrl_next;
      run_d_reg    <= i_prog_run;
      month_d_reg  <= i_time_month;
      mem_reg      <= mem_next;
      wp_reg       <= wp_next;
      rp_reg       <= rp_next;
      overrun_reg  <= overrun_next;
      ct_pend_reg  <= ct_pend_next;
      ct_done_reg  <= ct_done_next;
      dstate_reg   <= dstate_next;
      rec_reg      <= rec_next;
      mux_reg      <= mux_next;
      kind_reg     <= kind_next;
      seq_reg      <= seq_next;
      sh_reg       <= sh_next;
      pub_reg      <= pub_next;
      pair_reg     <= pair_next;
      cr_reg       <= cr_next;
      stat_reg     <= stat_next;
      sr_reg       <= sr_next;
      hold_reg     <= hold_next;
      rdata_reg    <= rdata_next;
    end
  end

  assign o_rdata             = rdata_reg;
  assign o_din_word0         = din_word_reg[31:16];
  assign o_din_word1         = din_word_reg[15:0];
  assign o_transfer_status   = {8'h00, seq_reg, kind_reg};
  assign o_mux_word          = mux_reg;
  assign o_event_record      = rec_reg;
  assign o_event_ready_flag  = (dstate_reg == D_SHOW);
  assign o_counter_set       = pub_reg;
  assign o_counts_ready_flag = cr_reg;
  assign o_status_word       = stat_reg;
  assign o_status_ready_flag = sr_reg;

  // assertion helpers
  logic [1:0] age_reg;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      age_reg <= 2'h0;
    end else if (age_reg != 2'h3) begin
      age_reg <= age_reg + 2'h1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_din_refresh;
    (age_reg == 2'h3) |-> o_din_word0[15] == $past(i_din_pins[0], 3)
      && o_din_word1[0] == $past(i_din_pins[31], 3);
  endproperty
  a_din_refresh: assert property (p_din_refresh) else $error("din word stale"); // RQ1

  property p_counts_pulse;
    o_counts_ready_flag |=> !o_counts_ready_flag;
  endproperty
  a_counts_pulse: assert property (p_counts_pulse) else $error("counts flag long"); // RQ2

  property p_counts_only_on_flag;
    !o_counts_ready_flag && !$past(i_clear_counters) |-> $stable(o_counter_set);
  endproperty
  a_counts_only_on_flag: assert property (p_counts_only_on_flag)
    else $error("counter set changed without publish"); // RQ2

  property p_evt_hold;
    o_event_ready_flag && !i_event_accept && !cont
      |=> o_event_ready_flag && $stable(o_event_record);
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("event not held"); // RQ3

  property p_evt_gap;
    o_event_ready_flag && i_event_accept |=> !o_event_ready_flag ##1 !o_event_ready_flag;
  endproperty
  a_evt_gap: assert property (p_evt_gap) else $error("ready gap too short"); // RQ4 RQ7

  property p_cont_pulse;
    o_event_ready_flag && cont |=> !o_event_ready_flag;
  endproperty
  a_cont_pulse: assert property (p_cont_pulse) else $error("continuous pulse long"); // RQ7

  property p_clear_queue;
    i_clear_event_queue && !i_evt_valid |=> empty;
  endproperty
  a_clear_queue: assert property (p_clear_queue) else $error("queue not emptied"); // RQ8

  property p_clear_counters;
    i_clear_counters |=> o_counter_set == '0 && pair_reg == 4'h0;
  endproperty
  a_clear_counters: assert property (p_clear_counters) else $error("counters not cleared"); // RQ9

  property p_ti_ms;
    o_event_ready_flag && o_event_record[47] |-> o_event_record[39:24] == MS_INVALID;
  endproperty
  a_ti_ms: assert property (p_ti_ms) else $error("invalid time ms not all ones"); // RQ16

  property p_reserved_zero;
    o_event_ready_flag |-> !o_event_record[46] && o_event_record[54:53] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // RQ15 RQ17

  sequence s_ct_acked;
    o_event_ready_flag && o_event_record[7] && i_event_accept && !cont && !i_clear_event_queue
      ##1 !i_clear_event_queue && !cont ##1 !i_clear_event_queue && !cont;
  endsequence
  property p_ct_follow;
    s_ct_acked |=> o_event_ready_flag && !o_event_record[7];
  endproperty
  a_ct_follow: assert property (p_ct_follow) else $error("event missing after coarse"); // RQ20

  property p_status_hold;
    o_status_ready_flag |=> (!o_status_ready_flag && $stable(o_status_word))[*2];
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status replaced early"); // RQ21

  property p_reset_flags;
    @(posedge i_clk) disable iff (1'b0)
      i_rst |-> !o_event_ready_flag && !o_counts_ready_flag && !o_status_ready_flag
        && wp_reg == rp_reg;
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("flag set in reset"); // RQ24

  c_coarse:  cover property (o_event_ready_flag && o_event_record[7]);
  c_cont:    cover property (o_event_ready_flag && cont ##3 o_event_ready_flag);
  c_publish: cover property (o_counts_ready_flag);
  c_full:    cover property (full && i_evt_valid);
endmodule // tse_transfer
`default_nettype wire

// *** test/tse_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module tse_host_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // record side
  input  wire logic        i_ready,
  input  wire logic [63:0] i_record,
  // behaviour
  input  wire logic        i_stall,
  input  wire logic        i_hold,
  input  wire logic [3:0]  i_wait,
  output logic             o_accept,
  output logic [7:0]       o_count
);
  logic [63:0] recs [0:31];
  logic [3:0]  wait_reg;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_accept <= 1'b0;
      o_count  <= 8'h00;
      wait_reg <= 4'h0;
    end else if (i_hold) begin
      // no handshake protection here, so every pulse is taken at once
      o_accept <= 1'b1;
      if (i_ready) begin
        recs[o_count[4:0]] <= i_record;
        o_count            <= o_count + 8'h01;
      end
    end else if (!i_ready) begin
      o_accept <= 1'b0;
      wait_reg <= 4'h0;
    end else if (!o_accept && !i_stall) begin
      if (wait_reg == i_wait) begin
        recs[o_count[4:0]] <= i_record;
        o_count            <= o_count + 8'h01;
        o_accept           <= 1'b1;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule // tse_host_model
`default_nettype wire

// *** test/tb_time_stamp_event_transfer.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_time_stamp_event_transfer;
  import tse_pkg::*;
  logic        i_clk, i_rst, i_wr, i_rd, i_cnt_valid, i_evt_valid, i_time_invalid;
  logic        i_time_summer, i_clock_set, i_prog_run, i_event_accept, i_clear_event_queue;
  logic        i_clear_counters, o_event_ready_flag, o_counts_ready_flag;
  logic        o_status_ready_flag, stall, hold;
  logic [3:0]  i_addr, i_host_err, wt;
  logic [31:0] i_wdata, o_rdata, i_din_pins;
  logic [63:0] i_cnt_pair, o_mux_word, o_event_record;
  logic [1:0]  i_evt_type;
  logic [5:0]  i_evt_first, i_time_min;
  logic [7:0]  i_evt_states, i_time_month, i_time_year, got_n;
  logic [15:0] i_time_ms, o_din_word0, o_din_word1, o_transfer_status, o_status_word;
  logic [4:0]  i_time_hour, i_time_dom;
  logic [2:0]  i_time_dow;
  logic [8:0]  i_module_err;
  logic [NUM_CNT*CNT_W-1:0] o_counter_set;
  logic [63:0] exp_q [$];
  int          failures, check_count, rises, hi_len, max_hi, gap, min_gap;

  tse_transfer #(.FIFO_DEPTH(4)) uut (.*);
  tse_host_model host (.i_clk, .i_rst, .i_ready(o_event_ready_flag),
    .i_record(o_event_record), .i_stall(stall), .i_hold(hold), .i_wait(wt),
    .o_accept(i_event_accept), .o_count(got_n));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // sampled mid-cycle so registered flags have settled
  always @(negedge i_clk) begin
    gap = gap + 1;
    if (o_event_ready_flag === 1'b1) begin
      if (hi_len == 0) begin
        rises = rises + 1;
        if (gap < min_gap) min_gap = gap;
        gap = 0;
      end
      hi_len = hi_len + 1;
      if (hi_len > max_hi) max_hi = hi_len;
    end else hi_len = 0;
  end

  task automatic stats;
    rises = 0;
    max_hi = 0;
    min_gap = 99;
    gap = 99;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata, e);
  endtask

  function automatic logic [63:0] rec(input logic ct, input logic [7:0] b2, b3,
                                      input logic ti);
    rec = {i_time_dow, i_time_dom, i_time_summer, 2'b00, i_time_hour, ti, 1'b0,
           i_time_min, ti ? 16'hffff : i_time_ms, b3, b2, ct, 7'h2a};
  endfunction

  // the caller lowers the valid strobe, so pushes may run back to back
  task automatic push(input logic [1:0] ty, input logic [5:0] f, input logic [7:0] s,
                      input logic ti, input logic co);
    logic [7:0] m;
    m = (ty == EVT_SINGLE) ? 8'h01 : (ty == EVT_PAIR) ? 8'h03 : 8'hff;
    @(posedge i_clk);
    i_evt_valid <= 1'b1;
    i_evt_type <= ty;
    i_evt_first <= f;
    i_evt_states <= s;
    i_time_invalid <= ti;
    i_time_ms <= i_time_ms + 16'd1001;
    i_time_min <= i_time_min + 6'd1;
    i_time_hour <= i_time_hour + 5'd1;
    i_time_summer <= ~i_time_summer;
    i_time_dom <= i_time_dom + 5'd1;
    i_time_dow <= i_time_dow % 3'd7 + 3'd1;
    // expectation uses the time the design samples at the next edge
    @(negedge i_clk);
    if (co) exp_q.push_back(rec(1'b1, i_time_month, i_time_year, ti));
    exp_q.push_back(rec(1'b0, {ty, f}, s & m, ti));
  endtask

  task automatic deliver;
    for (int i = 0; i < 300 && got_n != exp_q.size(); i++) @(posedge i_clk);
    repeat (12) @(posedge i_clk);
    chk(64'(got_n), 64'(exp_q.size()));
    for (int i = 0; i < exp_q.size(); i++) chk(host.recs[i], exp_q[i]);
  endtask

  initial begin
    {i_wr, i_rd, i_cnt_valid, i_evt_valid, i_time_invalid, i_clock_set, i_prog_run} = '0;
    {i_clear_event_queue, i_clear_counters, stall, hold, failures, check_count} = '0;
    {i_addr, i_wdata, i_din_pins, i_cnt_pair, i_evt_type, i_evt_first} = '0;
    {i_evt_states, i_host_err, i_module_err, wt} = '0;
    {i_time_ms, i_time_min, i_time_hour, i_time_summer, i_time_dom, i_time_dow} =
      {16'd1234, 6'd33, 5'd5, 1'b1, 5'd3, 3'd3};
    {i_time_month, i_time_year} = {8'h06, 8'h18};
    stats();
    i_rst = 1'b1;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk({o_event_ready_flag, o_counts_ready_flag, o_status_ready_flag}, 0);
    rd(ADDR_CTRL, 32'(CTRL_RESET));
    rd(ADDR_LEVEL, 0);
    // coarse pending from reset: record pair for the first event
    wr(ADDR_CTRL, 32'haa);
    wr(4'h2, 32'h0);
    rd(4'h2, 0);
    wt <= 4'h3;
    push(EVT_SINGLE, 6'd5, 8'hff, 1'b0, 1'b1);
    @(posedge i_clk) i_evt_valid <= 1'b0;
    deliver();
    // program start is a coarse trigger as well
    @(posedge i_clk) i_prog_run <= 1'b1;
    push(EVT_PAIR, 6'd1, 8'h03, 1'b0, 1'b1);
    @(posedge i_clk) i_evt_valid <= 1'b0;
    deliver();
    // handshake with queued events, every type code
    wr(ADDR_CTRL, 32'h2a);
    rd(ADDR_CTRL, 32'h2a);
    wt <= 4'h5;
    stats();
    push(EVT_PAIR, 6'd3, 8'hfe, 1'b0, 1'b0);
    push(EVT_OCTET, 6'd9, 8'ha5, 1'b1, 1'b0);
    push(EVT_SINGLE, 6'd32, 8'h02, 1'b0, 1'b0);
    @(posedge i_clk) i_evt_valid <= 1'b0;
    deliver();
    chk(64'(rises), 3);
    // queue clear drops queued entries, shown one survives
    stall <= 1'b1;
    push(EVT_SINGLE, 6'd1, 8'h01, 1'b0, 1'b0);
    push(EVT_SINGLE, 6'd2, 8'h01, 1'b0, 1'b0);
    push(EVT_SINGLE, 6'd3, 8'h00, 1'b0, 1'b0);
    @(posedge i_clk) i_evt_valid <= 1'b0;
    repeat (10) @(posedge i_clk);
    i_clear_event_queue <= 1'b1;
    @(posedge i_clk) i_clear_event_queue <= 1'b0;
    void'(exp_q.pop_back());
    void'(exp_q.pop_back());
    stall <= 1'b0;
    deliver();
    rd(ADDR_LEVEL, 0);
    // continuous mode
    wr(ADDR_CTRL, 32'h12a);
    hold <= 1'b1;
    stats();
    push(EVT_PAIR, 6'd31, 8'h02, 1'b0, 1'b0);
    push(EVT_OCTET, 6'd25, 8'h3c, 1'b0, 1'b0);
    push(EVT_OCTET, 6'd17, 8'hc3, 1'b0, 1'b0);
    @(posedge i_clk) i_evt_valid <= 1'b0;
    deliver();
    chk(64'(max_hi), 1);
    chk(64'(min_gap >= 2), 1);
    hold <= 1'b0;
    wr(ADDR_CTRL, 32'h2a);
    // counter series of 8 values in four beats
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      i_cnt_valid <= 1'b1;
      i_cnt_pair <= {32'(257 + 2 * k), 32'(256 + 2 * k)};
      @(negedge i_clk);
      chk({o_counts_ready_flag, o_counter_set[31:0]}, 0);
    end
    @(posedge i_clk) i_cnt_valid <= 1'b0;
    @(negedge i_clk);
    chk(o_counts_ready_flag, 1);
    chk(o_mux_word, {32'd263, 32'd262});
    chk(64'(o_transfer_status[1:0]), 64'(MUX_COUNT));
    for (int k = 0; k < 8; k++) chk(o_counter_set[32*k +: 32], 32'(256 + k));
    @(negedge i_clk);
    chk(o_counts_ready_flag, 0);
    @(posedge i_clk) i_clear_counters <= 1'b1;
    @(posedge i_clk) i_clear_counters <= 1'b0;
    repeat (2) @(negedge i_clk);
    for (int k = 0; k < 8; k++) chk(o_counter_set[32*k +: 32], 0);
    // status word split and one-cycle flag
    @(posedge i_clk) {i_host_err, i_module_err, i_time_invalid} <= {4'h9, 9'h104, 1'b0};
    for (int i = 0; i < 40 && o_status_ready_flag !== 1'b1; i++) @(negedge i_clk);
    chk(o_status_word, 16'h9104);
    @(negedge i_clk);
    chk({o_status_ready_flag, o_status_word}, 17'h09104);
    @(negedge i_clk);
    chk(o_status_word, 16'h9104);
    rd(ADDR_STATUS, 32'h9104);
    // input 1 lands on bit 15 of the first word
    for (int j = 0; j < 2; j++) begin
      @(posedge i_clk) i_din_pins <= j ? 32'h0003_c000 : 32'h8000_0001;
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
      chk({o_din_word1, o_din_word0}, j ? 32'hc000_0003 : 32'h0001_8000);
    end
    stop_test();
  end

  initial begin
    #(25 * 20000);
    failures++;
    stop_test();
  end
endmodule // tb_time_stamp_event_transfer
`default_nettype wire
